// File: rtl/fsp_pkg.sv
package fsp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_SECURITY = 10'h101;
  localparam logic [9:0] IDX_TEST_MODE = 10'h102;
  localparam logic [9:0] IDX_CONFIG = 10'h103;
  localparam logic [9:0] IDX_PROTECT = 10'h104;
  localparam logic [9:0] IDX_STATUS = 10'h105;
  // Security register fields
  localparam int SEC_BACKDOOR_KEY_ENABLE_BIT = 7;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [7:0] SEC_RST = 8'h00;
  // Test mode register
  localparam int TST_WRITE_ALL_BANKS_BIT = 4;
  // Configuration register fields
  localparam int CFG_BEIE_BIT = 7;
  localparam int CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT = 6;
  localparam int CFG_KEY_ACCESS_MODE_BIT = 5;
  localparam int CFG_BANK_SELECT_BIT = 0;
  localparam logic [7:0] CFG_RST = 8'h00;
  // Protection register fields
  localparam int PR_OPEN_BIT = 7;
  localparam int PR_NV_BIT = 6;
  localparam int PR_HDIS_BIT = 5;
  localparam int PR_HS_LSB = 3;
  localparam int PR_LDIS_BIT = 2;
  localparam int PR_LS_LSB = 0;
  localparam logic [7:0] PR_RST = 8'h00;
  // Status register fields
  localparam int ST_BE_BIT = 7;
  localparam int ST_CC_BIT = 6;
  localparam int ST_PV_BIT = 5;
  localparam int ST_AE_BIT = 4;
  // Sector sizes in bytes for size code 00, and the block size in bytes
  localparam logic [15:0] HI_SIZE_BASE = 16'h0800;
  localparam logic [15:0] LO_SIZE_BASE = 16'h0200;
  localparam logic [15:0] BLOCK_SIZE = 16'h8000;
endpackage

// File: rtl/fsp_regs.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module fsp_regs (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] nv_security_byte_i,
  input wire logic [7:0] nv_protect_blk0_i,
  input wire logic [7:0] nv_protect_blk1_i,
  input wire logic super_user_mode_i,
  input wire logic special_mode_i,
  input wire logic backdoor_unlock_i,
  input wire logic array_write_i,
  input wire logic [15:0] array_addr_i,
  input wire logic array_mass_i,
  input wire logic [1:0] cmd_accept_i,
  input wire logic [1:0] cmd_idle_i,
  output logic secured_o,
  output logic backdoor_enable_o,
  output logic key_access_mode_o,
  output logic key_word_o,
  output logic pgm_grant_o,
  output logic [1:0] cmd_launch_o,
  output logic irq_o
);

  logic [7:0] security_options;
  logic write_all_banks;
  logic [7:0] flash_configuration;
  logic [7:0] sector_protection [2];
  logic [1:0] buffer_empty_flag;
  logic [1:0] all_commands_complete_flag;
  logic [1:0] protection_violation_flag;
  logic [1:0] access_error_flag;
  logic load_pending;
  logic bus_req;
  logic [9:0] idx;
  logic [7:0] wdat;
  logic lane0;
  logic bank_select;
  logic [1:0] wr_bank;
  logic sec_touch;
  logic prot_wr;
  logic stat_wr;
  logic array_bank;
  logic array_prot;
  logic array_viol;
  logic [7:0] next_rdat;

  // Is an address inside a sector protected by this protection byte?
  function automatic logic in_protected(input logic [7:0] pr,
                                        input logic [15:0] addr);
    logic [15:0] off;
    logic [15:0] hi_size;
    logic [15:0] lo_size;
    logic hit;
    off = {1'b0, addr[14:0]};
    hi_size = fsp_pkg::HI_SIZE_BASE << pr[fsp_pkg::PR_HS_LSB +: 2];
    lo_size = fsp_pkg::LO_SIZE_BASE << pr[fsp_pkg::PR_LS_LSB +: 2];
    hit = 1'b0;
    if (!pr[fsp_pkg::PR_HDIS_BIT] &&
        off >= (fsp_pkg::BLOCK_SIZE - hi_size)) begin
      hit = 1'b1;
    end
    if (!pr[fsp_pkg::PR_LDIS_BIT] && off < lo_size) begin
      hit = 1'b1;
    end
    if (!pr[fsp_pkg::PR_OPEN_BIT]) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[11:2];
  assign wdat = wb_dat_i[7:0];
  assign lane0 = wb_sel_i[0];
  assign bank_select = flash_configuration[fsp_pkg::CFG_BANK_SELECT_BIT];
  assign wr_bank[0] = write_all_banks || !bank_select;
  assign wr_bank[1] = write_all_banks || bank_select;
  assign sec_touch = bus_req && super_user_mode_i &&
                     (idx == fsp_pkg::IDX_SECURITY ||
                      idx == fsp_pkg::IDX_CONFIG ||
                      idx == fsp_pkg::IDX_PROTECT);
  assign prot_wr = bus_req && wb_we_i && lane0 && !super_user_mode_i &&
                   idx == fsp_pkg::IDX_PROTECT;
  assign stat_wr = bus_req && wb_we_i && lane0 &&
                   idx == fsp_pkg::IDX_STATUS;
  // Block 0 sits in the upper half of the map
  assign array_bank = !array_addr_i[15];
  assign array_prot = in_protected(sector_protection[array_bank],
                                   array_addr_i);
  // Mass erase needs open and both ranges disabled
  assign array_viol = array_mass_i ?
      !(sector_protection[array_bank][fsp_pkg::PR_OPEN_BIT] &&
        sector_protection[array_bank][fsp_pkg::PR_HDIS_BIT] &&
        sector_protection[array_bank][fsp_pkg::PR_LDIS_BIT]) :
      array_prot;

  // Option bytes are captured on the first edge after reset release
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end

  // No bus write path exists for this register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      security_options <= fsp_pkg::SEC_RST;
    end else if (load_pending) begin
      security_options <= nv_security_byte_i;
    end else if (backdoor_unlock_i &&
                 security_options[fsp_pkg::SEC_BACKDOOR_KEY_ENABLE_BIT]) begin
      security_options[1:0] <= fsp_pkg::SEC_UNSECURED;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      write_all_banks <= 1'b0;
    end else if (!special_mode_i) begin
      write_all_banks <= 1'b0;
    end else if (bus_req && wb_we_i && lane0 &&
                 idx == fsp_pkg::IDX_TEST_MODE) begin
      write_all_banks <= wdat[fsp_pkg::TST_WRITE_ALL_BANKS_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flash_configuration <= fsp_pkg::CFG_RST;
    end else if (bus_req && wb_we_i && lane0 && !super_user_mode_i &&
                 idx == fsp_pkg::IDX_CONFIG) begin
      flash_configuration <= wdat & 8'he1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sector_protection[0] <= fsp_pkg::PR_RST;
      sector_protection[1] <= fsp_pkg::PR_RST;
    end else if (load_pending) begin
      sector_protection[0] <= nv_protect_blk0_i;
      sector_protection[1] <= nv_protect_blk1_i;
    end else if (prot_wr) begin
      for (int b = 0; b < 2; b++) begin
        if (wr_bank[b]) begin
          sector_protection[b][fsp_pkg::PR_OPEN_BIT] <=
              sector_protection[b][fsp_pkg::PR_OPEN_BIT] &
              wdat[fsp_pkg::PR_OPEN_BIT];
          sector_protection[b][fsp_pkg::PR_HDIS_BIT] <=
              sector_protection[b][fsp_pkg::PR_HDIS_BIT] &
              wdat[fsp_pkg::PR_HDIS_BIT];
          sector_protection[b][fsp_pkg::PR_LDIS_BIT] <=
              sector_protection[b][fsp_pkg::PR_LDIS_BIT] &
              wdat[fsp_pkg::PR_LDIS_BIT];
          if (sector_protection[b][fsp_pkg::PR_HDIS_BIT]) begin
            sector_protection[b][fsp_pkg::PR_HS_LSB +: 2] <=
                wdat[fsp_pkg::PR_HS_LSB +: 2];
          end
          if (sector_protection[b][fsp_pkg::PR_LDIS_BIT]) begin
            sector_protection[b][fsp_pkg::PR_LS_LSB +: 2] <=
                wdat[fsp_pkg::PR_LS_LSB +: 2];
          end
        end
      end
    end
  end

  // Status flags; hardware sets other than command complete are ordered last so they beat clears
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buffer_empty_flag <= 2'h3;
      all_commands_complete_flag <= 2'h3;
      protection_violation_flag <= 2'h0;
      access_error_flag <= 2'h0;
      cmd_launch_o <= 2'h0;
    end else begin
      cmd_launch_o <= 2'h0;
      for (int b = 0; b < 2; b++) begin
        // Ordered first: a launch in this cycle leaves work pending
        if (cmd_idle_i[b] && buffer_empty_flag[b]) begin
          all_commands_complete_flag[b] <= 1'b1;
        end
        if (stat_wr && wr_bank[b]) begin
          if (wdat[fsp_pkg::ST_PV_BIT]) begin
            protection_violation_flag[b] <= 1'b0;
          end
          if (wdat[fsp_pkg::ST_AE_BIT]) begin
            access_error_flag[b] <= 1'b0;
          end
          if (!wdat[fsp_pkg::ST_BE_BIT]) begin
            access_error_flag[b] <= 1'b1;
          end else if (buffer_empty_flag[b] &&
                       !protection_violation_flag[b] &&
                       !access_error_flag[b]) begin
            buffer_empty_flag[b] <= 1'b0;
            all_commands_complete_flag[b] <= 1'b0;
            cmd_launch_o[b] <= 1'b1;
          end
        end
        if (cmd_accept_i[b]) begin
          buffer_empty_flag[b] <= 1'b1;
        end
        if (sec_touch && (b == 32'(bank_select))) begin
          access_error_flag[b] <= 1'b1;
        end
        if (array_write_i && !key_access_mode_o && array_viol &&
            (b == 32'(array_bank))) begin
          protection_violation_flag[b] <= 1'b1;
        end
      end
    end
  end

  // Reads never consult protection, so protected data reads back as stored
  always_comb begin
    next_rdat = 8'h00;
    case (idx)
      fsp_pkg::IDX_SECURITY: next_rdat = security_options;
      fsp_pkg::IDX_TEST_MODE: begin
        if (special_mode_i) begin
          next_rdat[fsp_pkg::TST_WRITE_ALL_BANKS_BIT] = write_all_banks;
        end
      end
      fsp_pkg::IDX_CONFIG: next_rdat = flash_configuration;
      fsp_pkg::IDX_PROTECT: next_rdat = sector_protection[bank_select];
      fsp_pkg::IDX_STATUS: begin
        next_rdat[fsp_pkg::ST_BE_BIT] = buffer_empty_flag[bank_select];
        next_rdat[fsp_pkg::ST_CC_BIT] =
            all_commands_complete_flag[bank_select];
        next_rdat[fsp_pkg::ST_PV_BIT] =
            protection_violation_flag[bank_select];
        next_rdat[fsp_pkg::ST_AE_BIT] = access_error_flag[bank_select];
      end
      default: next_rdat = 8'h00;
    endcase
  end

  // Every access, mapped or not, answers one cycle later
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, next_rdat};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      secured_o <= 1'b1;
      backdoor_enable_o <= 1'b0;
      key_access_mode_o <= 1'b0;
      key_word_o <= 1'b0;
      pgm_grant_o <= 1'b0;
    end else begin
      secured_o <= security_options[1:0] != fsp_pkg::SEC_UNSECURED;
      backdoor_enable_o <= security_options[fsp_pkg::SEC_BACKDOOR_KEY_ENABLE_BIT];
      key_access_mode_o <= flash_configuration[fsp_pkg::CFG_KEY_ACCESS_MODE_BIT];
      key_word_o <= array_write_i && key_access_mode_o;
      pgm_grant_o <= array_write_i && !key_access_mode_o &&
                     !array_viol;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (flash_configuration[fsp_pkg::CFG_BEIE_BIT] &&
                |buffer_empty_flag) ||
               (flash_configuration[fsp_pkg::CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT] &&
                |all_commands_complete_flag);
    end
  end

  property p_sec_readonly;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (!load_pending && !backdoor_unlock_i) |=> $stable(security_options);
  endproperty
  a_sec_readonly: assert property (p_sec_readonly)
    else $error("security register changed without load or unlock");

  property p_su_error;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    sec_touch |=> access_error_flag[$past(bank_select)];
  endproperty
  a_su_error: assert property (p_su_error)
    else $error("super-user access did not set access error");

  property p_unlock;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (backdoor_unlock_i && !load_pending && backdoor_enable_o) |=>
      security_options[1:0] == 2'h2 ##1 !secured_o;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("backdoor unlock did not unsecure");

  property p_secured;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    ##1 secured_o == ($past(security_options[1:0]) != 2'h2);
  endproperty
  a_secured: assert property (p_secured)
    else $error("secured output disagrees with security field");

  property p_test_zero;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (bus_req && !wb_we_i && idx == fsp_pkg::IDX_TEST_MODE &&
     !special_mode_i) |=> wb_ack_o && wb_dat_o == 32'h0000_0000;
  endproperty
  a_test_zero: assert property (p_test_zero)
    else $error("test register not zero in normal mode");

  property p_irq;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (flash_configuration[7] && buffer_empty_flag[0]) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("buffer-empty interrupt missing");

  property p_open_only_clears;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !load_pending |=> !$rose(sector_protection[0][7]) &&
                      !$rose(sector_protection[1][7]);
  endproperty
  a_open_only_clears: assert property (p_open_only_clears)
    else $error("open bit was set by software");

  property p_violation;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (array_write_i && !key_access_mode_o && array_viol) |=>
      protection_violation_flag[$past(array_bank)] && !pgm_grant_o;
  endproperty
  a_violation: assert property (p_violation)
    else $error("protected program did not flag violation");

  property p_launch_blocked;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (stat_wr && wr_bank[0] &&
     (protection_violation_flag[0] || access_error_flag[0])) |=>
      !cmd_launch_o[0];
  endproperty
  a_launch_blocked: assert property (p_launch_blocked)
    else $error("command launched while an error flag was set");

  property p_complete_clears;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    cmd_launch_o != 2'h0 |->
      (cmd_launch_o & (all_commands_complete_flag | buffer_empty_flag)) ==
      2'h0;
  endproperty
  a_complete_clears: assert property (p_complete_clears)
    else $error("launch left complete or empty flag set");

endmodule

// File: test/fsp_engine_model.sv
`timescale 1ns/1ps
// Flash command engine: takes a launch, empties the buffer, then goes idle
module fsp_engine_model #(
  parameter int ACCEPT_DLY = 10,
  parameter int DONE_DLY = 20
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] cmd_launch_i,
  output logic [1:0] cmd_accept_o,
  output logic [1:0] cmd_idle_o
);
  int cnt [2];
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '{0, 0};
      cmd_accept_o <= 2'h0;
      cmd_idle_o <= 2'h3;
    end else begin
      for (int b = 0; b < 2; b++) begin
        cmd_accept_o[b] <= (cnt[b] == ACCEPT_DLY);
        if (cmd_launch_i[b]) begin
          cnt[b] <= 1;
          cmd_idle_o[b] <= 1'b0;
        end else if (cnt[b] == DONE_DLY) begin
          cnt[b] <= 0;
          cmd_idle_o[b] <= 1'b1;
        end else if (cnt[b] != 0) begin
          cnt[b] <= cnt[b] + 1;
        end
      end
    end
  end
endmodule

// File: test/test_flash_security_protection_regs.sv
`timescale 1ns/1ps
module test_flash_security_protection_regs;
  localparam logic [9:0] R_SEC = fsp_pkg::IDX_SECURITY;
  localparam logic [9:0] R_TST = fsp_pkg::IDX_TEST_MODE;
  localparam logic [9:0] R_CFG = fsp_pkg::IDX_CONFIG;
  localparam logic [9:0] R_PR = fsp_pkg::IDX_PROTECT;
  localparam logic [9:0] R_ST = fsp_pkg::IDX_STATUS;
  localparam logic [7:0] NV_P0 = 8'he5;
  localparam logic [7:0] NV_P1 = 8'h84;
  logic core_clk, arst_n, cyc, stb, we, sum, spec, unl, aw, mass;
  logic ack, secured, bden, kam, kw, grant, irq, g, k;
  logic [11:0] adr;
  logic [31:0] dat, rdat;
  logic [15:0] aa;
  logic [1:0] acc, idle, launch;
  logic [7:0] q, nvs;
  int bad_count = 0;
  int checks_done = 0;
  int l0 = 0;

  fsp_regs dut_u (.core_clk_i(core_clk), .arst_n_i(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .nv_security_byte_i(nvs), .nv_protect_blk0_i(NV_P0),
    .nv_protect_blk1_i(NV_P1), .super_user_mode_i(sum),
    .special_mode_i(spec), .backdoor_unlock_i(unl), .array_write_i(aw),
    .array_addr_i(aa), .array_mass_i(mass), .cmd_accept_i(acc),
    .cmd_idle_i(idle), .secured_o(secured), .backdoor_enable_o(bden),
    .key_access_mode_o(kam), .key_word_o(kw), .pgm_grant_o(grant),
    .cmd_launch_o(launch), .irq_o(irq));

  fsp_engine_model eng_u (.core_clk_i(core_clk), .arst_n_i(arst_n),
    .cmd_launch_i(launch), .cmd_accept_o(acc), .cmd_idle_o(idle));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (launch[0] === 1'b1) l0++;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Holds the request until ack is sampled, so no cycle is ever dropped
  task wb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    dat <= {24'h0, d};
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("rdat_hi", 8'h00, rdat[15:8]);
  endtask

  task rd(input logic [9:0] i, input string nm, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(nm, e, q);
  endtask

  task arr(input logic [15:0] a, input logic m);
    @(posedge core_clk);
    aw <= 1'b1;
    aa <= a;
    mass <= m;
    @(posedge core_clk);
    aw <= 1'b0;
    mass <= 1'b0;
    g = 1'b0;
    k = 1'b0;
    // Grant and key word pulse for one cycle starting at this edge
    repeat (3) begin
      #1;
      g |= grant;
      k |= kw;
      @(posedge core_clk);
    end
  endtask

  task pulse_unlock;
    @(posedge core_clk);
    unl <= 1'b1;
    @(posedge core_clk);
    unl <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task t_security;
    rd(R_SEC, "security", 8'hd5);
    chk("secured", 8'h1, {7'h0, secured});
    chk("key_enable", 8'h1, {7'h0, bden});
    wb(1'b1, R_SEC, 8'h00);
    rd(R_SEC, "security_ro", 8'hd5);
    rd(10'h0ff, "unmapped", 8'h00);
    pulse_unlock();
    rd(R_SEC, "security_unlocked", 8'hd6);
    chk("secured_after", 8'h0, {7'h0, secured});
    $display("test security done");
  endtask

  task t_protect;
    logic [15:0] ad [7];
    logic ex [7];
    ad = '{16'hc000, 16'hbfff, 16'h87ff, 16'h8800, 16'h7800, 16'h77ff,
      16'h0000};
    ex = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    rd(R_PR, "prot0", NV_P0);
    rd(R_CFG, "config", 8'h00);
    wb(1'b1, R_CFG, 8'h01);
    rd(R_PR, "prot1", NV_P1);
    wb(1'b1, R_CFG, 8'h00);
    wb(1'b1, R_PR, 8'hbe);
    rd(R_PR, "prot_sizes", 8'hfe);
    arr(16'h8000, 1'b1);
    chk("mass_open", 8'h1, {7'h0, g});
    wb(1'b1, R_PR, 8'h9a);
    rd(R_PR, "prot_clear", 8'hda);
    wb(1'b1, R_PR, 8'ha5);
    rd(R_PR, "prot_locked", 8'hda);
    for (int i = 0; i < 7; i++) begin
      arr(ad[i], 1'b0);
      chk("grant", {7'h0, ex[i]}, {7'h0, g});
      if (i < 4) rd(R_ST, "viol", ex[i] ? 8'hc0 : 8'he0);
      if (i < 4 && !ex[i]) wb(1'b1, R_ST, 8'ha0);
    end
    rd(R_ST, "viol_cleared", 8'hc0);
    chk("no_launch", 8'h0, 8'(l0));
    arr(16'h8000, 1'b1);
    chk("mass_locked", 8'h0, {7'h0, g});
    wb(1'b1, R_PR, 8'h5a);
    arr(16'h9000, 1'b0);
    chk("closed", 8'h0, {7'h0, g});
    wb(1'b1, R_ST, 8'ha0);
    $display("test protection done");
  endtask

  task t_launch;
    logic [7:0] cf [4];
    logic [7:0] ei [4];
    cf = '{8'h00, 8'h80, 8'h40, 8'h00};
    ei = '{8'h0, 8'h1, 8'h1, 8'h0};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, R_CFG, cf[i]);
      repeat (3) @(posedge core_clk);
      chk("irq", ei[i], {7'h0, irq});
    end
    wb(1'b1, R_ST, 8'h80);
    rd(R_ST, "busy", 8'h00);
    chk("launch", 8'h1, 8'(l0));
    repeat (30) @(posedge core_clk);
    rd(R_ST, "done", 8'hc0);
    wb(1'b1, R_ST, 8'h00);
    rd(R_ST, "err", 8'hd0);
    wb(1'b1, R_ST, 8'h80);
    wb(1'b1, R_ST, 8'h90);
    rd(R_ST, "err_cleared", 8'hc0);
    chk("blocked", 8'h1, 8'(l0));
    $display("test launch done");
  endtask

  task t_modes;
    wb(1'b1, R_TST, 8'h10);
    rd(R_TST, "test_normal", 8'h00);
    spec <= 1'b1;
    wb(1'b1, R_TST, 8'h10);
    rd(R_TST, "test_special", 8'h10);
    wb(1'b1, R_ST, 8'h00);
    rd(R_ST, "all_bank0", 8'hd0);
    wb(1'b1, R_CFG, 8'h01);
    rd(R_ST, "all_bank1", 8'hf0);
    wb(1'b1, R_ST, 8'hb0);
    rd(R_ST, "all_clr1", 8'hc0);
    wb(1'b1, R_CFG, 8'h00);
    rd(R_ST, "all_clr0", 8'hc0);
    wb(1'b1, R_TST, 8'h00);
    spec <= 1'b0;
    sum <= 1'b1;
    wb(1'b1, R_CFG, 8'h01);
    sum <= 1'b0;
    rd(R_CFG, "su_config", 8'h00);
    rd(R_ST, "su_err", 8'hd0);
    wb(1'b1, R_ST, 8'h90);
    wb(1'b1, R_CFG, 8'h20);
    repeat (2) @(posedge core_clk);
    chk("key_mode", 8'h1, {7'h0, kam});
    arr(16'h8800, 1'b0);
    chk("key_word", 8'h1, {7'h0, k});
    chk("key_nogrant", 8'h0, {7'h0, g});
    wb(1'b1, R_CFG, 8'h00);
    $display("test modes done");
  endtask

  // Second reset with the key disabled: unlock must be ignored
  task t_reset2;
    nvs <= 8'h41;
    arst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    pulse_unlock();
    rd(R_SEC, "locked", 8'h41);
    chk("key_off", 8'h0, {7'h0, bden});
    chk("still_secured", 8'h1, {7'h0, secured});
    $display("test second reset done");
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    {cyc, stb, we, sum, spec, unl, aw, mass} = 8'h00;
    adr = 12'h000;
    dat = 32'h0;
    aa = 16'h0000;
    nvs = 8'hd5;
    arst_n = 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_security();
    t_protect();
    t_launch();
    t_modes();
    t_reset2();
    give_verdict();
  end
endmodule
